// File: logic/usbft_pkg.sv
// usbft_pkg: constants and types of the frame timing counters
// assumes a 20 MHz clock and a 12 Mbit/s full-speed bit time
package usbft_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int BIT_HZ = 12_000_000;
  localparam int PERIOD_W = 14;
  localparam int COUNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int TOGGLE_POS = 31;
  localparam int RUN_POS = 0;
  localparam int IDX_PERIOD = 8'h0D;
  localparam int IDX_REMAIN = 8'h0E;
  localparam int IDX_COUNT = 8'h0F;
  localparam int IDX_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = ADDR_W'(IDX_PERIOD * 4);
  localparam logic [ADDR_W-1:0] ADDR_REMAIN = ADDR_W'(IDX_REMAIN * 4);
  localparam logic [ADDR_W-1:0] ADDR_COUNT = ADDR_W'(IDX_COUNT * 4);
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(IDX_CONTROL * 4);
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 14'h2EDF;
  localparam logic [PERIOD_W-1:0] BITS_LEFT_RST = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [31:0] DATA_RST = 32'h00000000;

  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_DONE = 3'b010,
    APB_SPARE = 3'b100
  } usbft_apb_t;
endpackage

// File: logic/usbft_tick_if.sv
// usbft_tick_if: bit-time enable between divider and frame timer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface usbft_tick_if;
  logic bitTick;
  modport source (output bitTick);
  modport sink (input bitTick);
endinterface
`default_nettype wire

// File: logic/usbft_bit_tick.sv
// usbft_bit_tick: fractional divider giving one-cycle bit-time enables
// assumes clkHz above bitHz; average rate equals bitHz exactly
`timescale 1ns/1ps
`default_nettype none
module usbft_bit_tick #(
  parameter int clkHz = usbft_pkg::CLK_HZ,
  parameter int bitHz = usbft_pkg::BIT_HZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bit-time enable
  usbft_tick_if.source tick
);
  import usbft_pkg::*;
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] STEP = ACC_W'(bitHz);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(clkHz);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } usbft_div_t;

  usbft_div_t s_q;
  usbft_div_t s_d;
  logic [ACC_W-1:0] sum;

  always_comb begin
    s_d = s_q;
    sum = s_q.acc + STEP;
    if (sum >= WRAP) begin
      s_d.acc = sum - WRAP;
      s_d.tick = 1'b1;
    end else begin
      s_d.acc = sum;
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick.bitTick = s_q.tick;
endmodule
`default_nettype wire

// File: logic/usbft_frame_timer.sv
// usbft_frame_timer: frame remaining and frame count registers on APB
// assumes a 32-bit APB master on the same clock; one wait state per access
`timescale 1ns/1ps
`default_nettype none
module usbft_frame_timer (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usbft_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status
  output logic busRunning,
  output logic frameStart
);
  import usbft_pkg::*;

  typedef struct packed {
    usbft_apb_t apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PERIOD_W-1:0] framePeriodBits;
    logic intervalToggle;
    logic running;
    logic [PERIOD_W-1:0] bitsLeftInFrame;
    logic remainingToggle;
    logic [COUNT_W-1:0] frameCountValue;
    logic frameStart;
  } usbft_state_t;

  usbft_state_t s_q;
  usbft_state_t s_d;
  usbft_tick_if tickBus ();
  logic bitTick;
  logic writeNow;
  logic enterRun;
  logic mapped;
  logic readOnly;
  logic [31:0] readWord;

  usbft_bit_tick #(
    .clkHz(CLK_HZ),
    .bitHz(BIT_HZ)
  ) divider (
    .clock(clock),
    .reset(reset),
    .tick(tickBus.source)
  );

  assign bitTick = tickBus.bitTick;
  assign writeNow = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
  assign enterRun = writeNow && (paddr == ADDR_CONTROL) && pwdata[RUN_POS] && !s_q.running;
  assign mapped = (paddr == ADDR_PERIOD) || (paddr == ADDR_REMAIN) ||
                  (paddr == ADDR_COUNT) || (paddr == ADDR_CONTROL);
  assign readOnly = (paddr == ADDR_REMAIN) || (paddr == ADDR_COUNT);

  // read mux, reserved bits zero
  always_comb begin
    readWord = DATA_RST;
    case (paddr)
      ADDR_PERIOD: begin
        readWord[TOGGLE_POS] = s_q.intervalToggle;
        readWord[PERIOD_W-1:0] = s_q.framePeriodBits;
      end
      ADDR_REMAIN: begin
        readWord[TOGGLE_POS] = s_q.remainingToggle;
        readWord[PERIOD_W-1:0] = s_q.bitsLeftInFrame;
      end
      ADDR_COUNT: begin
        readWord[COUNT_W-1:0] = s_q.frameCountValue;
      end
      ADDR_CONTROL: begin
        readWord[RUN_POS] = s_q.running;
      end
      default: begin
        readWord = DATA_RST;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.frameStart = 1'b0;
    // apb phases: answer on second access cycle
    case (s_q.apb)
      APB_IDLE: begin
        if (psel && penable) begin
          s_d.apb = APB_DONE;
          s_d.pready = 1'b1;
          s_d.pslverr = !mapped || (pwrite && readOnly);
          s_d.prdata = pwrite ? DATA_RST : readWord;
        end
      end
      APB_DONE: begin
        s_d.apb = APB_IDLE;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
      end
      default: begin
        s_d.apb = APB_IDLE;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
      end
    endcase
    if (writeNow && paddr == ADDR_PERIOD) begin
      s_d.framePeriodBits = pwdata[PERIOD_W-1:0];
      s_d.intervalToggle = pwdata[TOGGLE_POS];
    end
    if (writeNow && paddr == ADDR_CONTROL) begin
      s_d.running = pwdata[RUN_POS];
    end
    if (enterRun) begin
      s_d.bitsLeftInFrame = s_q.framePeriodBits;
    end else if (s_q.running && bitTick) begin
      if (s_q.bitsLeftInFrame == BITS_LEFT_RST) begin
        s_d.bitsLeftInFrame = s_q.framePeriodBits;
        s_d.remainingToggle = s_q.intervalToggle;
        s_d.frameCountValue = s_q.frameCountValue + 16'h0001;
        s_d.frameStart = 1'b1;
      end else begin
        s_d.bitsLeftInFrame = s_q.bitsLeftInFrame - 14'h0001;
      end
    end
    // hold while not running, except on the write that enters running (no branch taken)
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.apb <= APB_IDLE;
      s_q.prdata <= DATA_RST;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.framePeriodBits <= PERIOD_RST;
      s_q.intervalToggle <= 1'b0;
      s_q.running <= 1'b0;
      s_q.bitsLeftInFrame <= BITS_LEFT_RST;
      s_q.remainingToggle <= 1'b0;
      s_q.frameCountValue <= COUNT_RST;
      s_q.frameStart <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign busRunning = s_q.running;
  assign frameStart = s_q.frameStart;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // zero reached on a bit time
  logic frameEnd;
  assign frameEnd = s_q.running && bitTick && !enterRun &&
                    s_q.bitsLeftInFrame == BITS_LEFT_RST;

  sequence readRemain;
    pready && !pwrite && paddr == ADDR_REMAIN;
  endsequence

  sequence periodCommit;
    writeNow && paddr == ADDR_PERIOD;
  endsequence

  sequence runCommit;
    writeNow && paddr == ADDR_CONTROL;
  endsequence

  sequence zeroTick;
    s_q.running && bitTick && !enterRun && s_q.bitsLeftInFrame == 14'h0000;
  endsequence

  sequence accessWait;
    psel && penable && !pready;
  endsequence

  reload_on_zero_a: assert property (zeroTick |=> (s_q.bitsLeftInFrame ==
      $past(s_q.framePeriodBits)) && frameStart)
    else $error("counter not reloaded after reaching zero");

  count_down_a: assert property (s_q.running && bitTick && !enterRun &&
      s_q.bitsLeftInFrame != 14'h0000 |=>
      s_q.bitsLeftInFrame == $past(s_q.bitsLeftInFrame) - 14'h0001)
    else $error("counter did not drop by one");

  toggle_copy_a: assert property (zeroTick |=>
      s_q.remainingToggle == $past(s_q.intervalToggle))
    else $error("remaining toggle not copied");

  hold_when_idle_a: assert property (!s_q.running && !enterRun |=>
      $stable(s_q.bitsLeftInFrame))
    else $error("counter moved outside running state");

  run_entry_a: assert property (enterRun |=> s_q.running &&
      s_q.bitsLeftInFrame == $past(s_q.framePeriodBits))
    else $error("counter not reloaded on entering running state");

  remain_read_a: assert property (pready && !pwrite && paddr == ADDR_REMAIN |->
      prdata[30:14] == 17'h00000 &&
      prdata[13:0] == $past(s_q.bitsLeftInFrame))
    else $error("remaining register read wrong");

  count_read_a: assert property (pready && !pwrite && paddr == ADDR_COUNT |->
      prdata == {16'h0000, $past(s_q.frameCountValue)})
    else $error("frame count read wrong");

  frame_step_a: assert property (zeroTick |=> s_q.frameCountValue ==
      $past(s_q.frameCountValue) + 16'h0001)
    else $error("frame count did not step");

  period_reset_a: assert property (disable iff (1'b0) reset |=>
      s_q.framePeriodBits == PERIOD_RST && !busRunning)
    else $error("period not at default after reset");

  apb_answer_a: assert property (accessWait |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  start_after_zero_a: assert property (frameStart |-> $past(frameEnd))
    else $error("frame start without counter at zero");

  count_hold_a: assert property (!frameEnd |=> $stable(s_q.frameCountValue))
    else $error("frame count moved outside a frame start");

  toggle_hold_a: assert property (!frameEnd |=> $stable(s_q.remainingToggle))
    else $error("remaining toggle moved outside a frame start");

  remain_toggle_a: assert property (readRemain |->
      prdata[TOGGLE_POS] == $past(s_q.remainingToggle))
    else $error("remaining toggle read wrong");

  remain_ro_a: assert property (psel && penable && !pready && pwrite &&
      paddr == ADDR_REMAIN |=> pready && pslverr)
    else $error("write to remaining register accepted");

  count_ro_a: assert property (psel && penable && !pready && pwrite &&
      paddr == ADDR_COUNT |=> pready && pslverr)
    else $error("write to frame count accepted");

  entry_quiet_a: assert property (enterRun |=> !frameStart)
    else $error("frame start on entering running state");

  // period write lands
  period_write_a: assert property (periodCommit |=>
      s_q.framePeriodBits == $past(pwdata[PERIOD_W-1:0]) &&
      s_q.intervalToggle == $past(pwdata[TOGGLE_POS]))
    else $error("period write not taken");

  // control write lands
  run_write_a: assert property (runCommit |=> busRunning == $past(pwdata[RUN_POS]))
    else $error("run bit write not taken");

  // apb answer shape
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");

  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  unmapped_err_a: assert property (psel && penable && !pready && !mapped |=> pslverr)
    else $error("unmapped access not refused");

  read_clean_a: assert property (psel && penable && !pready && !pwrite && mapped |=>
      pready && !pslverr)
    else $error("mapped read refused");

  // read data holds between answers
  rdata_hold_a: assert property (!(psel && penable && !pready) |=> $stable(prdata))
    else $error("read data moved between answers");
endmodule
`default_nettype wire

// File: tb/usbft_host_model.sv
// usbft_host_model: apb master standing in for the host driver software
// assumes the frame timer as apb slave on the same rising clock
`timescale 1ns/1ps
`default_nettype none
module usbft_host_model (
  // clock
  input wire logic clock,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [usbft_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import usbft_pkg::*;
  logic toggle = 1'b0;
  logic [31:0] frames32 = 32'h00000000;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // one transfer, held until pready or 20 cycles
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok = (pready === 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setPeriod(input logic [PERIOD_W-1:0] p, output logic e, output logic ok);
    logic [31:0] q;
    toggle = ~toggle;
    xfer(1'b1, ADDR_PERIOD, {toggle, 17'h00000, p}, q, e, ok);
  endtask
  task automatic readFrames(output logic ok);
    logic [31:0] q;
    logic e;
    xfer(1'b0, ADDR_COUNT, 32'h00000000, q, e, ok);
    if (q[15:0] < frames32[15:0]) frames32[31:16]++;
    frames32[15:0] = q[15:0];
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// tb: register level bench of the frame timing counters
// assumes the host model drives apb; only mismatches and verdict print
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usbft_pkg::*;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, busRunning, frameStart, e, ok;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q, held;
  int errorCnt = 0;
  int testsRun = 0;
  int gap;
  localparam logic [PERIOD_W-1:0] PER = 14'h0014;
  usbft_frame_timer u_usbft_frame_timer (.clock, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .busRunning, .frameStart);
  usbft_host_model u_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  task automatic tallyAndFinish;
    if (errorCnt == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang;
    chk(32'h0, 32'h1, "wait timed out");
    tallyAndFinish();
  endtask
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic expErr);
    u_host.xfer(w, a, d, q, e, ok);
    if (!ok) hang();
    chk(32'(e), 32'(expErr), "slave error");
  endtask
  task automatic waitFrame;
    gap = 0;
    do begin
      @(posedge clock);
      gap++;
    end while (frameStart !== 1'b1 && gap < 200);
    if (gap >= 200) hang();
  endtask
  task automatic remainNear(input logic tog);
    acc(1'b0, ADDR_REMAIN, 32'h0, 1'b0);
    chk({q[31:14]}, {tog, 17'h0}, "remain upper");
    chk(32'(q[13:0] > PER - 14'h0007 && q[13:0] <= PER), 32'h1, "remain range");
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    acc(1'b0, ADDR_REMAIN, 32'h0, 1'b0);
    chk(q, DATA_RST, "remain reset");
    acc(1'b0, ADDR_COUNT, 32'h0, 1'b0);
    chk(q, DATA_RST, "count reset");
    acc(1'b0, ADDR_PERIOD, 32'h0, 1'b0);
    chk(q, 32'h00002EDF, "period reset");
    acc(1'b1, ADDR_REMAIN, 32'hFFFFFFFF, 1'b1);
    acc(1'b1, ADDR_COUNT, 32'hFFFFFFFF, 1'b1);
    acc(1'b0, 8'h44, 32'h0, 1'b1);
    u_host.setPeriod(PER, e, ok);
    if (!ok) hang();
    chk(32'(e), 32'h0, "period write");
    acc(1'b1, ADDR_CONTROL, 32'h00000001, 1'b0);
    @(posedge clock);
    chk(32'(busRunning), 32'h1, "running");
    remainNear(1'b0);
    waitFrame();
    remainNear(1'b1);
    u_host.readFrames(ok);
    if (!ok) hang();
    chk(u_host.frames32, 32'h1, "first frame");
    waitFrame();
    waitFrame();
    chk(32'(gap > 32 && gap < 38), 32'h1, "frame length");
    u_host.readFrames(ok);
    if (!ok) hang();
    chk(u_host.frames32, 32'h3, "frame count");
    acc(1'b1, ADDR_CONTROL, 32'h0, 1'b0);
    acc(1'b0, ADDR_REMAIN, 32'h0, 1'b0);
    held = q;
    chk(32'(busRunning), 32'h0, "stopped");
    repeat (40) @(posedge clock);
    acc(1'b0, ADDR_REMAIN, 32'h0, 1'b0);
    chk(q, held, "stopped hold");
    u_host.setPeriod(PER, e, ok);
    if (!ok) hang();
    chk(32'(e), 32'h0, "period rewrite");
    acc(1'b1, ADDR_CONTROL, 32'h00000001, 1'b0);
    waitFrame();
    remainNear(1'b0);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
